// ---- hw/bsn_core.sv ----
// Command handling, broadcast selection and I/O line notification.
//
// The implementer's own choices: the address map and the APB interface to the registers.
module bsn_core
  import bsn_pkg::*;
#(
  parameter int          LINES    = 8,
  parameter int          HOLD     = HOLD_CYC,
  parameter int          BOOT_LEN = BOOT_LEN_DEF,
  // Arbitrary version value, BCD x.xx.
  parameter logic [11:0] VERSION  = 12'h100
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic             i_ce,
  input  wire logic             i_psel,
  input  wire logic             i_penable,
  input  wire logic             i_pwrite,
  input  wire logic [7:0]       i_paddr,
  input  wire logic [31:0]      i_pwdata,
  output logic      [31:0]      o_prdata,
  output logic                  o_pready,
  output logic                  o_pslverr,
  input  wire logic             i_cmd_valid,
  input  wire bsn_cmd_t         i_cmd,
  output logic                  o_cmd_ready,
  output logic                  o_cmd_fwd,
  output bsn_reply_t            o_reply,
  input  wire logic             i_session_open,
  input  wire logic [31:0]      i_session_ip,
  output logic      [15:0]      o_boot_addr,
  input  wire logic [7:0]       i_boot_data,
  input  wire logic [15:0]      i_boot_sum,
  output logic                  o_boot_launch,
  input  wire logic [LINES-1:0] i_io,
  input  wire logic             i_data_conn,
  input  wire logic             i_cmd_phase,
  output bsn_note_t             o_note,
  input  wire logic             i_note_ready,
  input  wire logic             i_peer_valid,
  input  wire logic [7:0]       i_peer_levels,
  output logic                  o_rts,
  output logic                  o_dtr
);

  // ------------------------------------------------------------------
  // Derived sizes
  // ------------------------------------------------------------------
  // The hold counter is sized from the hold time so that a shortened
  // hold for test does not carry a wide counter around with it.
  localparam int CW = $clog2(HOLD + 1);
  localparam logic [CW-1:0] HOLD_C = CW'(HOLD);
  localparam logic [15:0]   LEN_C  = 16'(BOOT_LEN);

  typedef struct packed {
    bsn_cfg_t              cfg;
    logic [15:0]           dest;
    logic [47:0]           mac;
    logic                  sel;
    logic                  rts;
    logic                  dtr;
    logic [LINES-1:0]      io_m;
    logic [LINES-1:0]      io_s;
    logic [LINES-1:0]      ref_lvl;
    logic [LINES-1:0][CW-1:0] cnt;
    bsn_fsm_t              fsm;
    logic [15:0]           addr;
    logic                  rdv;
    logic [15:0]           sum;
    bsn_reply_t            reply;
    bsn_note_t             note;
    logic                  launch;
    logic                  fwd;
    logic [31:0]           prdata;
  } bsn_state_t;

  // All state lives in one record: the current copy is registered and
  // the next copy is built in a single combinational process.
  bsn_state_t st;
  bsn_state_t next_st;

  logic       apb_wr;
  logic       apb_setup;
  logic       addr_ok;
  logic       take;
  logic       mine;
  logic       bc_free;
  logic [LINES-1:0] fire;
  logic [7:0] lvl_byte;

  // ------------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------------
  always_comb begin
    addr_ok = (i_paddr == ADDR_CFG) || (i_paddr == ADDR_DEST) ||
              (i_paddr == ADDR_STAT) || (i_paddr == ADDR_MAC_LO) ||
              (i_paddr == ADDR_MAC_HI);
    apb_setup = i_psel && !i_penable;
    apb_wr = i_psel && i_penable && i_pwrite && addr_ok;
  end

  // The slave never inserts wait states of its own. While the clock
  // enable is low nothing can be written, so the access is stretched.
  assign o_pready  = i_ce;
  assign o_pslverr = i_psel && i_penable && !addr_ok;
  assign o_prdata  = st.prdata;

  // ------------------------------------------------------------------
  // Command acceptance
  // ------------------------------------------------------------------
  // Broadcasts of any command outside the free set need the selection;
  // a directly addressed command never looks at it.
  always_comb begin
    bc_free = (i_cmd.code == CMD_SELECT) ||
              (i_cmd.code == CMD_VERSION) ||
              (i_cmd.code == CMD_ECHO);
    mine = i_cmd.has_mac && (i_cmd.mac == st.mac);
    take = 1'b0;
    if (i_cmd_valid && o_cmd_ready) begin
      if (i_cmd.serial) begin
        take = (i_cmd.code == CMD_VERSION);
      end else if (i_cmd.bcast) begin
        take = bc_free || st.sel;
      end else begin
        take = 1'b1;
      end
    end
  end

  // Only one command is in flight at a time. The checksum walk and the
  // reply cycle hold ready low, so the framer never sees two replies
  // overlap and no command is lost while the loader is being checked.
  assign o_cmd_ready = (st.fsm == BSN_ST_IDLE) && !st.reply.valid;

  // ------------------------------------------------------------------
  // Line watch
  // ------------------------------------------------------------------
  // The reported byte is built from the synchronised pin levels, so a
  // bit reads one when the module pin is high. Any transceiver on the
  // board inverts this; that is left to whoever reads the message.
  always_comb begin
    lvl_byte = '0;
    lvl_byte[LINES-1:0] = st.io_s;
  end

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    next_st = st;
    fire = '0;
    next_st.reply.valid = 1'b0;
    next_st.launch = 1'b0;
    next_st.fwd = 1'b0;

    // Two flip-flops bring the pins into this clock; only the second
    // one is read by any logic.
    next_st.io_m = i_io;
    next_st.io_s = st.io_m;

    // Read data is loaded in the setup cycle and stands through the
    // access cycle, so the bus sees a registered value at its edge.
    if (apb_setup) begin
      next_st.prdata = 32'h0000_0000;
      case (i_paddr)
        ADDR_CFG: begin
          next_st.prdata[13:0] = st.cfg;
        end
        ADDR_DEST: begin
          next_st.prdata[15:0] = st.dest;
        end
        ADDR_STAT: begin
          next_st.prdata[0] = st.sel;
          next_st.prdata[1] = st.rts;
          next_st.prdata[2] = st.dtr;
          next_st.prdata[3] = st.note.valid;
          next_st.prdata[15:8] = lvl_byte;
        end
        ADDR_MAC_LO: begin
          next_st.prdata = st.mac[31:0];
        end
        ADDR_MAC_HI: begin
          next_st.prdata[15:0] = st.mac[47:32];
        end
        default: begin
          next_st.prdata = 32'h0000_0000;
        end
      endcase
    end

    if (apb_wr) begin
      case (i_paddr)
        ADDR_CFG: begin
          next_st.cfg = i_pwdata[13:0];
        end
        ADDR_DEST: begin
          next_st.dest = i_pwdata[15:0];
        end
        ADDR_MAC_LO: begin
          next_st.mac[31:0] = i_pwdata;
        end
        ADDR_MAC_HI: begin
          next_st.mac[47:32] = i_pwdata[15:0];
        end
        default: begin
          next_st.dest = st.dest;
        end
      endcase
    end

    // ------------------------------------------------------------------
    // Commands
    // ------------------------------------------------------------------
    // A select command with an address always updates the selection,
    // but only the device that recognised itself answers. The session
    // is checked before the loader walk so a denied jump costs nothing.
    if (take) begin
      case (i_cmd.code)
        CMD_SELECT: begin
          if (!i_cmd.has_mac) begin
            next_st.sel = 1'b0;
          end else begin
            next_st.sel = mine;
          end
          if (mine) begin
            next_st.reply.valid = 1'b1;
            next_st.reply.code = CODE_OK;
            next_st.reply.with_ver = 1'b0;
          end
        end
        CMD_VERSION: begin
          // The framer wraps the version as <Vx.xx> behind the code.
          next_st.reply.valid = 1'b1;
          next_st.reply.code = CODE_OK;
          next_st.reply.with_ver = 1'b1;
          next_st.reply.version = VERSION;
        end
        CMD_BOOT: begin
          if (!i_session_open || (i_cmd.src_ip != i_session_ip)) begin
            next_st.reply.valid = 1'b1;
            next_st.reply.code = CODE_DENIED;
            next_st.reply.with_ver = 1'b0;
          end else begin
            next_st.fsm = BSN_ST_SUM;
            next_st.addr = 16'h0000;
            next_st.sum = 16'h0000;
            next_st.rdv = 1'b0;
          end
        end
        default: begin
          next_st.fwd = 1'b1;
        end
      endcase
    end

    // Checksum over the stored loader, one byte a cycle; the store
    // answers one cycle after the address.
    case (st.fsm)
      BSN_ST_IDLE: begin
        next_st.rdv = 1'b0;
      end
      BSN_ST_SUM: begin
        if (st.rdv) begin
          next_st.sum = st.sum + {8'h00, i_boot_data};
        end
        if (st.addr != LEN_C) begin
          next_st.addr = st.addr + 16'h0001;
          next_st.rdv = 1'b1;
        end else begin
          next_st.rdv = 1'b0;
          if (!st.rdv) begin
            next_st.fsm = BSN_ST_CHECK;
          end
        end
      end
      BSN_ST_CHECK: begin
        next_st.fsm = BSN_ST_IDLE;
        next_st.reply.valid = 1'b1;
        next_st.reply.with_ver = 1'b0;
        if (st.sum == i_boot_sum) begin
          next_st.reply.code = CODE_OK;
          next_st.launch = 1'b1;
        end else begin
          next_st.reply.code = CODE_FAILED;
        end
      end
      default: begin
        next_st.fsm = BSN_ST_IDLE;
      end
    endcase

    // ------------------------------------------------------------------
    // Line watch
    // ------------------------------------------------------------------
    // Per-line stability watch. Unwatched lines follow the pin so that
    // enabling them later does not report an old change.
    for (int i = 0; i < LINES; i++) begin
      if (!st.cfg.mask[i] || !i_data_conn) begin
        next_st.ref_lvl[i] = st.io_s[i];
        next_st.cnt[i] = '0;
      end else if (st.io_s[i] == st.ref_lvl[i]) begin
        next_st.cnt[i] = '0;
      end else if (st.cnt[i] == HOLD_C) begin
        fire[i] = 1'b1;
        next_st.ref_lvl[i] = st.io_s[i];
        next_st.cnt[i] = '0;
      end else begin
        next_st.cnt[i] = st.cnt[i] + CW'(1);
      end
    end

    // ------------------------------------------------------------------
    // Notification out
    // ------------------------------------------------------------------
    // A new report while one is pending overwrites it, since only the
    // latest line levels matter to the host. A report raised in the
    // same cycle as the host takes the old one wins over the clear.
    if (st.note.valid && i_note_ready) begin
      next_st.note.valid = 1'b0;
    end
    if (!i_data_conn) begin
      next_st.note.valid = 1'b0;
    end else if (|fire) begin
      next_st.note.valid = 1'b1;
      next_st.note.kind = MSG_NOTIFY;
      next_st.note.levels = lvl_byte;
      next_st.note.port = st.dest;
      if (st.cfg.login && st.cfg.transport && i_cmd_phase) begin
        next_st.note.route = BSN_RT_CMD;
        next_st.note.esc = 1'b0;
      end else if (st.cfg.inband && st.cfg.transport) begin
        next_st.note.route = BSN_RT_INBAND;
        next_st.note.esc = 1'b1;
      end else begin
        next_st.note.route = BSN_RT_UDP;
        next_st.note.esc = 1'b0;
      end
    end

    // ------------------------------------------------------------------
    // Peer notification in
    // ------------------------------------------------------------------
    // A received notification gives no reply of any kind. Each output
    // keeps its level whenever its setting says it is owned elsewhere.
    if (i_peer_valid) begin
      if (!st.cfg.flow_ctl && st.cfg.full_duplex) begin
        next_st.rts = i_peer_levels[BIT_PEER_RTS];
      end
      if (!st.cfg.dtr_mode) begin
        next_st.dtr = i_peer_levels[BIT_PEER_DTR];
      end
    end
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  // Reset leaves the device deselected with nothing pending; the clock
  // enable freezes every field, the synchronisers included.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st <= '0;
      st.dest <= DEST_RESET;
      st.fsm <= BSN_ST_IDLE;
      st.note.route <= BSN_RT_UDP;
    end else if (i_ce) begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  // Every output below comes straight from the state record, so none of them
  // can glitch with the command or bus inputs.
  assign o_reply       = st.reply;
  assign o_note        = st.note;
  assign o_boot_addr   = st.addr;
  assign o_boot_launch = st.launch;
  assign o_cmd_fwd     = st.fwd;
  assign o_rts         = st.rts;
  assign o_dtr         = st.dtr;

endmodule

// ---- hw/bsn_pkg.sv ----
// Constants and types for the broadcast select and I/O notify block.
package bsn_pkg;
  localparam logic [7:0]  ADDR_CFG      = 8'h00;
  localparam logic [7:0]  ADDR_DEST     = 8'h04;
  localparam logic [7:0]  ADDR_STAT     = 8'h08;
  localparam logic [7:0]  ADDR_MAC_LO   = 8'h0c;
  localparam logic [7:0]  ADDR_MAC_HI   = 8'h10;
  localparam logic [7:0]  CODE_OK       = 8'h41;
  localparam logic [7:0]  CODE_DENIED   = 8'h44;
  localparam logic [7:0]  CODE_FAILED   = 8'h46;
  localparam logic [7:0]  CMD_SELECT    = 8'h57;
  localparam logic [7:0]  CMD_VERSION   = 8'h56;
  localparam logic [7:0]  CMD_BOOT      = 8'h4e;
  localparam logic [7:0]  CMD_ECHO      = 8'h58;
  localparam logic [7:0]  MSG_NOTIFY    = 8'h4a;
  localparam int          BIT_PEER_RTS  = 4;
  localparam int          BIT_PEER_DTR  = 2;
  localparam logic [15:0] DEST_RESET    = 16'h0000;
  localparam int          CLK_HZ        = 25000000;
  localparam int          HOLD_MS       = 500;
  localparam int          HOLD_CYC      = CLK_HZ / 1000 * HOLD_MS;
  localparam int          BOOT_LEN_DEF  = 1024;
  typedef enum logic [1:0] {
    BSN_RT_CMD,
    BSN_RT_INBAND,
    BSN_RT_UDP
  } bsn_route_t;
  typedef enum logic [1:0] {
    BSN_ST_IDLE,
    BSN_ST_SUM,
    BSN_ST_CHECK
  } bsn_fsm_t;
  typedef struct packed {
    logic        dtr_mode;
    logic        full_duplex;
    logic        flow_ctl;
    logic        inband;
    logic        transport;
    logic        login;
    logic [7:0]  mask;
  } bsn_cfg_t;
  typedef struct packed {
    logic [7:0]  code;
    logic        bcast;
    logic        serial;
    logic        has_mac;
    logic [47:0] mac;
    logic [31:0] src_ip;
  } bsn_cmd_t;
  typedef struct packed {
    logic        valid;
    logic [7:0]  code;
    logic        with_ver;
    logic [11:0] version;
  } bsn_reply_t;
  typedef struct packed {
    logic        valid;
    logic [7:0]  kind;
    logic [7:0]  levels;
    bsn_route_t  route;
    logic        esc;
    logic [15:0] port;
  } bsn_note_t;
endpackage

// ---- bench/bsn_core_sva.sv ----
// Port checker for the broadcast select and notify core.
module bsn_core_chk
  import bsn_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_rst,
  input wire logic        i_ce,
  input wire logic        i_cmd_valid,
  input wire bsn_cmd_t    i_cmd,
  input wire logic        o_cmd_ready,
  input wire bsn_reply_t  o_reply,
  input wire logic        o_boot_launch,
  input wire logic        i_session_open,
  input wire logic [31:0] i_session_ip,
  input wire logic        i_data_conn,
  input wire bsn_note_t   o_note,
  input wire logic        i_note_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic tk, dir, own;
  assign tk = i_cmd_valid && o_cmd_ready && i_ce;
  assign dir = tk && i_cmd.code == CMD_BOOT && !i_cmd.serial &&
               !i_cmd.bcast;
  assign own = i_session_open && i_session_ip == i_cmd.src_ip;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // ----------
  // Properties
  // ----------
  a_version_ok: assert property (tk && i_cmd.code == CMD_VERSION
    |=> o_reply.valid && o_reply.code == CODE_OK && o_reply.with_ver)
    else $error("version reply wrong");
  a_boot_denied: assert property (dir && !own
    |=> o_reply.valid && o_reply.code == CODE_DENIED)
    else $error("boot jump not denied");
  a_launch_ok: assert property (o_boot_launch
    |-> o_reply.valid && o_reply.code == CODE_OK)
    else $error("launch without ok");
  a_select_nomac: assert property (
    tk && i_cmd.code == CMD_SELECT && !i_cmd.has_mac |=> !o_reply.valid)
    else $error("reply to empty select");
  a_serial_drop: assert property (
    tk && i_cmd.serial && i_cmd.code != CMD_VERSION |=> !o_reply.valid)
    else $error("serial command answered");
  a_note_kind: assert property (o_note.valid |-> o_note.kind == MSG_NOTIFY)
    else $error("note kind wrong");
  a_note_conn: assert property (!i_data_conn |=> !o_note.valid)
    else $error("note without connection");
  a_note_held: assert property (
    o_note.valid && !i_note_ready && i_data_conn |=> o_note.valid)
    else $error("note dropped");
  c_launch: cover property (o_boot_launch);
  c_taken: cover property (o_note.valid && i_note_ready);
  c_denied: cover property (o_reply.valid && o_reply.code == CODE_DENIED);
endmodule
bind bsn_core bsn_core_chk u_chk (
  .i_clk, .i_rst, .i_ce, .i_cmd_valid, .i_cmd, .o_cmd_ready, .o_reply,
  .o_boot_launch, .i_session_open, .i_session_ip, .i_data_conn, .o_note,
  .i_note_ready);

// ---- bench/bsn_host.sv ----
// Remote host model that takes notifications with random stalls.
module bsn_host
  import bsn_pkg::*;
(
  input  wire logic      i_clk,
  input  wire logic      i_rst,
  input  wire bsn_note_t i_note,
  output logic           o_ready,
  output int             o_count,
  output bsn_note_t      o_last
);
  timeunit 1ns;
  timeprecision 1ns;
  // The host only takes notes and never answers them.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_ready <= 1'b0;
      o_count <= 0;
      o_last <= '0;
    end else begin
      o_ready <= ($urandom % 4) != 0;
      if (i_note.valid && o_ready) begin
        o_count <= o_count + 1;
        o_last <= i_note;
      end
    end
  end
endmodule

// ---- bench/tb.sv ----
// Self-checking bench for the broadcast select and notify core.
module tb;
  import bsn_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BLEN = 8;
  localparam int HOLD = 20;
  localparam logic [11:0] VER = 12'h100;
  typedef struct packed {
    logic [7:0] code;
    logic       bc, se, hm, gm, ss, gi, bs, sel, nr;
    logic [7:0] rc;
  } bsn_tc_t;
  localparam bsn_tc_t TC [12] = '{
    '{CMD_VERSION, 0,1,0,0,0,0,0,0,1, CODE_OK},
    '{CMD_ECHO, 0,1,0,0,0,0,0,0,0, 0},
    '{CMD_VERSION, 1,0,0,0,0,0,0,0,1, CODE_OK},
    '{CMD_SELECT, 1,0,1,0,0,0,0,0,0, 0},
    '{CMD_BOOT, 1,0,0,0,1,1,0,0,0, 0},
    '{CMD_SELECT, 1,0,1,1,0,0,0,1,1, CODE_OK},
    '{CMD_BOOT, 1,0,0,0,0,1,0,1,1, CODE_DENIED},
    '{CMD_BOOT, 0,0,0,0,1,0,0,1,1, CODE_DENIED},
    '{CMD_BOOT, 1,0,0,0,1,1,1,1,1, CODE_FAILED},
    '{CMD_SELECT, 1,0,0,0,0,0,0,0,0, 0},
    '{CMD_BOOT, 1,0,0,0,1,1,0,0,0, 0},
    '{CMD_BOOT, 0,0,0,0,1,1,0,0,1, CODE_OK}};
  // Route modes as {login, transport, inband, command phase}.
  localparam logic [3:0] RT [4] = '{4'hd, 4'he, 4'h7, 4'hb};
  logic        i_clk, i_rst, i_ce, i_psel, i_penable, i_pwrite, o_pready;
  logic        o_pslverr, i_cmd_valid, o_cmd_ready, o_cmd_fwd, o_rts;
  logic        i_session_open, o_boot_launch, i_data_conn, i_cmd_phase;
  logic        i_note_ready, i_peer_valid, o_dtr, err, er, ed, fc, fd, dt;
  logic [3:0]  m;
  logic [7:0]  i_paddr, i_boot_data, i_peer_levels, i_io, v;
  logic [15:0] o_boot_addr, i_boot_sum, dest;
  logic [31:0] i_pwdata, o_prdata, i_session_ip, q;
  logic [47:0] mac;
  bsn_cmd_t    i_cmd;
  bsn_reply_t  o_reply, rep;
  bsn_note_t   o_note, hlast;
  bsn_tc_t     t;
  int          failures, samples_checked, cyc, nrep, nl, n0, l0, hc, b;
  int          nf, f0;
  bsn_core #(.HOLD(HOLD), .BOOT_LEN(BLEN), .VERSION(VER)) u_dut (
    .i_clk, .i_rst, .i_ce, .i_psel, .i_penable, .i_pwrite, .i_paddr,
    .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_cmd_valid, .i_cmd,
    .o_cmd_ready, .o_cmd_fwd, .o_reply, .i_session_open, .i_session_ip,
    .o_boot_addr, .i_boot_data, .i_boot_sum, .o_boot_launch, .i_io,
    .i_data_conn, .i_cmd_phase, .o_note, .i_note_ready, .i_peer_valid,
    .i_peer_levels, .o_rts, .o_dtr);
  bsn_host u_host (.i_clk, .i_rst, .i_note(o_note), .o_ready(i_note_ready),
    .o_count(hc), .o_last(hlast));
  function automatic logic [7:0] bdat(input logic [15:0] a);
    return a[7:0] ^ 8'h5a;
  endfunction
  function automatic logic [15:0] bsum();
    logic [15:0] s;
    s = '0;
    for (int a = 0; a < BLEN; a++) s += 16'(bdat(16'(a)));
    return s;
  endfunction
  function automatic bsn_route_t xroute(input logic [3:0] r);
    if (r[3] && r[2] && r[0]) return BSN_RT_CMD;
    if (r[1] && r[2]) return BSN_RT_INBAND;
    return BSN_RT_UDP;
  endfunction
  task automatic chk(input string s, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", s, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    do @(posedge i_clk); while (o_pready !== 1'b1);
    q = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic summarize();
    $display("failures %0d samples_checked %0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  // The loader store answers one cycle after the address, as a memory would.
  always @(posedge i_clk) begin
    i_boot_data <= bdat(o_boot_addr);
    cyc <= cyc + 1;
    if (o_reply.valid) rep <= o_reply;
    nrep <= nrep + int'(o_reply.valid);
    nl <= nl + int'(o_boot_launch);
    nf <= nf + int'(o_cmd_fwd);
    if (cyc == 20000) begin
      failures++;
      summarize();
    end
  end
  // ---------
  // Scenarios
  // ---------
  initial begin
    void'($urandom(22));
    {i_psel, i_penable, i_pwrite, i_cmd_valid, i_session_open} = '0;
    {i_data_conn, i_cmd_phase, i_peer_valid, i_peer_levels, i_io} = '0;
    {i_paddr, i_pwdata, i_boot_sum, i_cmd, i_boot_data} = '0;
    i_ce = 1'b1;
    i_rst = 1'b1;
    mac = {16'($urandom), 32'($urandom)};
    i_session_ip = $urandom;
    repeat (6) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    apb(0, ADDR_STAT, 0);
    chk("status", 0, q);
    apb(0, 8'h20, 0);
    chk("slverr", 1, {31'h0, err});
    apb(1, ADDR_MAC_LO, mac[31:0]);
    apb(1, ADDR_MAC_HI, {16'h0, mac[47:32]});
    foreach (TC[k]) begin
      t = TC[k];
      n0 = nrep;
      l0 = nl;
      f0 = nf;
      i_session_open <= t.ss;
      i_boot_sum <= t.bs ? ~bsum() : bsum();
      i_cmd <= '{t.code, t.bc, t.se, t.hm, t.gm ? mac : ~mac,
                 t.gi ? i_session_ip : ~i_session_ip};
      i_cmd_valid <= 1'b1;
      @(posedge i_clk);
      i_cmd_valid <= 1'b0;
      repeat (BLEN + 8) @(posedge i_clk);
      chk("replies", 32'(t.nr), 32'(nrep - n0));
      if (t.nr) chk("code", 32'(t.rc), 32'(rep.code));
      if (t.nr && t.code == CMD_VERSION)
        chk("version", {1'b1, VER}, {rep.with_ver, rep.version});
      chk("launch", 32'(t.nr && t.rc == CODE_OK && t.code == CMD_BOOT),
          32'(nl - l0));
      chk("forward", 0, 32'(nf - f0));
      apb(0, ADDR_STAT, 0);
      chk("selected", 32'(t.sel), 32'(q[0]));
    end
    dest = 16'($urandom);
    apb(1, ADDR_DEST, {16'h0, dest});
    i_data_conn <= 1'b1;
    for (int r = 0; r < 4; r++) begin
      b = $urandom % 8;
      m = RT[r];
      i_cmd_phase <= m[0];
      apb(1, ADDR_CFG, {21'h0, m[1], m[2], m[3], 8'h1 << b});
      n0 = hc;
      i_io <= i_io ^ ~(8'h1 << b);
      repeat (HOLD + 20) @(posedge i_clk);
      chk("unwatched", n0, hc);
      i_io <= i_io ^ (8'h1 << b);
      repeat (HOLD / 2) @(posedge i_clk);
      i_io <= i_io ^ (8'h1 << b);
      repeat (HOLD + 20) @(posedge i_clk);
      chk("glitch", n0, hc);
      v = 8'($urandom);
      v[b] = ~i_io[b];
      i_io <= v;
      repeat (HOLD + 20) @(posedge i_clk);
      chk("notes", n0 + 1, hc);
      chk("levels", v, hlast.levels);
      chk("route", xroute(m), hlast.route);
      chk("escape", xroute(m) == BSN_RT_INBAND, hlast.esc);
      chk("port", dest, hlast.port);
    end
    i_data_conn <= 1'b0;
    n0 = hc;
    i_io <= ~i_io;
    repeat (HOLD + 20) @(posedge i_clk);
    chk("offline", n0, hc);
    {er, ed} = 2'b00;
    repeat (12) begin
      {fc, fd, dt} = 3'($urandom);
      apb(1, ADDR_CFG, {18'h0, dt, fd, fc, 11'h0});
      i_peer_levels <= 8'($urandom);
      i_peer_valid <= 1'b1;
      n0 = nrep;
      @(posedge i_clk);
      i_peer_valid <= 1'b0;
      if (!fc && fd) er = i_peer_levels[4];
      if (!dt) ed = i_peer_levels[2];
      @(posedge i_clk);
      chk("rts", er, o_rts);
      chk("dtr", ed, o_dtr);
      chk("peer reply", n0, nrep);
    end
    summarize();
  end
endmodule
